// *** hw/gpioc_top.sv ***
// Dual GPIO port block with port B change interrupt, AXI4-Lite slave
//
// Design decision made here: register access over AXI4-Lite.
module gpioc_top
  import gpioc_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst,
  // AXI4-Lite write channels
  input  wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                  i_s_axi_awvalid,
  output logic                       o_s_axi_awready,
  input  wire logic [31:0]           i_s_axi_wdata,
  input  wire logic [3:0]            i_s_axi_wstrb,
  input  wire logic                  i_s_axi_wvalid,
  output logic                       o_s_axi_wready,
  output logic [1:0]                 o_s_axi_bresp,
  output logic                       o_s_axi_bvalid,
  input  wire logic                  i_s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic                  i_s_axi_arvalid,
  output logic                       o_s_axi_arready,
  output logic [31:0]                o_s_axi_rdata,
  output logic [1:0]                 o_s_axi_rresp,
  output logic                       o_s_axi_rvalid,
  input  wire logic                  i_s_axi_rready,
  // Port A pins
  input  wire logic [PA_W-1:0]       i_pa_pin,
  output logic [PA_W-1:0]            o_pa_out,
  output logic [PA_W-1:0]            o_pa_oe_n,
  // Port B pins
  input  wire logic [PB_W-1:0]       i_pb_pin,
  output logic [PB_W-1:0]            o_pb_out,
  output logic [PB_W-1:0]            o_pb_oe_n,
  output logic [PB_W-1:0]            o_pb_pullup_en,
  // Alternate pin functions
  output logic                       o_timer_clk_in,
  output logic                       o_ext_irq_in,
  output logic                       o_prog_clk,
  output logic                       o_prog_data,
  // Core side
  input  wire logic                  i_sleep,
  output logic                       o_change_irq,
  output logic                       o_wake
);

  // Pin synchronisers
  logic [PA_W-1:0] pa_s1_q;
  logic [PA_W-1:0] pa_s2_q;
  logic [PB_W-1:0] pb_s1_q;
  logic [PB_W-1:0] pb_s2_q;

  // Bus state
  logic                  aw_have_q;
  logic                  aw_have_d;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic                  w_have_q;
  logic                  w_have_d;
  logic [7:0]            wdata_q;
  logic                  wstrb0_q;
  logic                  awready_q;
  logic                  wready_q;
  logic                  bvalid_q;
  logic                  bvalid_d;
  logic [1:0]            bresp_q;
  logic                  arready_q;
  logic                  rvalid_q;
  logic                  rvalid_d;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;

  // Block registers
  logic [PA_W-1:0] lat_a_q;
  logic [PA_W-1:0] lat_a_d;
  logic [PB_W-1:0] lat_b_q;
  logic [PB_W-1:0] lat_b_d;
  logic [7:0]      cfg_q;
  logic [7:0]      cfg_d;
  logic [PA_W-1:0] dir_a_q;
  logic [PA_W-1:0] dir_a_d;
  logic [PB_W-1:0] dir_b_q;
  logic [PB_W-1:0] dir_b_d;
  logic            chg_en_q;
  logic            chg_en_d;
  logic            chg_flag_q;
  logic            chg_flag_d;
  logic [3:0]      cmp_q;
  logic [3:0]      cmp_d;
  logic [2:0]      stab_cnt_q;
  logic [2:0]      stab_cnt_d;

  // Pin drive registers
  logic [PA_W-1:0] pa_out_q;
  logic [PA_W-1:0] pa_oe_n_q;
  logic [PB_W-1:0] pb_out_q;
  logic [PB_W-1:0] pb_oe_n_q;
  logic [PB_W-1:0] pullup_q;
  logic [3:0]      alt_q;
  logic            irq_q;
  logic            wake_q;

  // Handshake terms
  wire aw_take = i_s_axi_awvalid & awready_q;
  wire w_take  = i_s_axi_wvalid & wready_q;
  wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  wire ar_take = i_s_axi_arvalid & arready_q;

  assign aw_have_d = (aw_have_q & ~wr_fire) | aw_take;
  assign w_have_d  = (w_have_q & ~wr_fire) | w_take;
  assign bvalid_d  = (bvalid_q & ~i_s_axi_bready) | wr_fire;
  assign rvalid_d  = (rvalid_q & ~i_s_axi_rready) | ar_take;

  // Write decode
  wire [7:0] wr_idx  = awaddr_q[9:2];
  wire       wr_low  = (awaddr_q[AXI_ADDR_W-1:10] == 2'h0);
  wire       wr_en   = wr_fire & wstrb0_q;
  wire       wr_pa   = wr_en & wr_low & (wr_idx == IDX_PORT_A_DATA);
  wire       wr_pb   = wr_en & wr_low & (wr_idx == IDX_PORT_B_DATA);
  wire       wr_ic   = wr_en & wr_low & (wr_idx == IDX_INTERRUPT_CTRL);
  wire       wr_cfg  = wr_en & wr_low & (wr_idx == IDX_TIMER_PULLUP_CFG);
  wire       wr_da   = wr_en & wr_low & (wr_idx == IDX_PORT_A_DIRECTION);
  wire       wr_db   = wr_en & wr_low & (wr_idx == IDX_PORT_B_DIRECTION);
  wire       wr_hit  = wr_low & ((wr_idx == IDX_PORT_A_DATA) | (wr_idx == IDX_PORT_B_DATA)
                     | (wr_idx == IDX_INTERRUPT_CTRL) | (wr_idx == IDX_TIMER_PULLUP_CFG)
                     | (wr_idx == IDX_PORT_A_DIRECTION) | (wr_idx == IDX_PORT_B_DIRECTION));

  // Read decode
  wire [7:0] rd_idx  = i_s_axi_araddr[9:2];
  wire       rd_low  = (i_s_axi_araddr[AXI_ADDR_W-1:10] == 2'h0);
  wire       rd_pa   = rd_low & (rd_idx == IDX_PORT_A_DATA);
  wire       rd_pb   = rd_low & (rd_idx == IDX_PORT_B_DATA);
  wire       rd_ic   = rd_low & (rd_idx == IDX_INTERRUPT_CTRL);
  wire       rd_cfg  = rd_low & (rd_idx == IDX_TIMER_PULLUP_CFG);
  wire       rd_da   = rd_low & (rd_idx == IDX_PORT_A_DIRECTION);
  wire       rd_db   = rd_low & (rd_idx == IDX_PORT_B_DIRECTION);
  wire       rd_hit  = rd_pa | rd_pb | rd_ic | rd_cfg | rd_da | rd_db;

  // Interrupt control image
  wire [7:0] ic_img  = (8'({chg_en_q}) << CHG_IRQ_ENABLE_BIT)
                     | (8'({chg_flag_q}) << CHG_FLAG_BIT);

  // Read data selection
  wire [7:0] rd_byte = rd_pa  ? {3'h0, pa_s2_q} :
                       rd_pb  ? pb_s2_q :
                       rd_ic  ? ic_img :
                       rd_cfg ? cfg_q :
                       rd_da  ? {3'h0, dir_a_q} :
                       rd_db  ? dir_b_q :
                                8'h00;

  // Latch updates, input bits take the pin level
  assign lat_a_d = wr_pa ? ((dir_a_q & pa_s2_q) | (~dir_a_q & wdata_q[PA_W-1:0]))
                         : lat_a_q;
  assign lat_b_d = wr_pb ? ((dir_b_q & pb_s2_q) | (~dir_b_q & wdata_q))
                         : lat_b_q;
  assign cfg_d   = wr_cfg ? wdata_q : cfg_q;
  assign dir_a_d = wr_da ? wdata_q[PA_W-1:0] : dir_a_q;
  assign dir_b_d = wr_db ? wdata_q : dir_b_q;
  assign chg_en_d = wr_ic ? wdata_q[CHG_IRQ_ENABLE_BIT] : chg_en_q;

  // Change detection on the upper nibble
  wire [3:0] up_pins = pb_s2_q[PB_W-1:PB_CHG_LO];
  wire [3:0] up_in   = dir_b_q[PB_W-1:PB_CHG_LO];
  wire       mism    = |((up_pins ^ cmp_q) & up_in);
  wire       chg_hit = mism & (stab_cnt_q == CHG_CNT_MAX);

  assign stab_cnt_d = ~mism ? 3'h0 :
                      (stab_cnt_q == CHG_CNT_MAX) ? stab_cnt_q :
                      stab_cnt_q + 3'h1;
  assign cmp_d      = ((ar_take & rd_pb) | wr_pb) ? up_pins : cmp_q;

  // Set wins over a software clear
  assign chg_flag_d = chg_hit | (wr_ic ? wdata_q[CHG_FLAG_BIT] : chg_flag_q);

  // Pin synchronisers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pa_s1_q <= '0;
      pa_s2_q <= '0;
      pb_s1_q <= '0;
      pb_s2_q <= '0;
    end else begin
      pa_s1_q <= i_pa_pin;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= i_pb_pin;
      pb_s2_q <= pb_s1_q;
    end
  end

  // Write channels
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= ~aw_have_d & ~bvalid_d;
      wready_q  <= ~w_have_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
    end
  end

  // Write payload and response
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      awaddr_q <= '0;
      wdata_q  <= 8'h00;
      wstrb0_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_q <= i_s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q  <= i_s_axi_wdata[7:0];
        wstrb0_q <= i_s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channels
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Configuration and data registers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      lat_a_q  <= PORT_A_LATCH_RST;
      lat_b_q  <= PORT_B_LATCH_RST;
      cfg_q    <= TIMER_PULLUP_CFG_RST;
      dir_a_q  <= PORT_A_DIR_RST;
      dir_b_q  <= PORT_B_DIR_RST;
      chg_en_q <= 1'b0;
    end else begin
      lat_a_q  <= lat_a_d;
      lat_b_q  <= lat_b_d;
      cfg_q    <= cfg_d;
      dir_a_q  <= dir_a_d;
      dir_b_q  <= dir_b_d;
      chg_en_q <= chg_en_d;
    end
  end

  // Change detection state
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_q      <= 4'h0;
      stab_cnt_q <= 3'h0;
      chg_flag_q <= 1'b0;
    end else begin
      cmp_q      <= cmp_d;
      stab_cnt_q <= stab_cnt_d;
      chg_flag_q <= chg_flag_d;
    end
  end

  // Pin drive next values
  logic [PA_W-1:0] pa_out_d;
  logic [PA_W-1:0] pa_oe_n_d;
  logic [PB_W-1:0] pullup_d;
  logic [3:0]      alt_d;
  logic            irq_d;
  logic            wake_d;
  wire  [PA_W-1:0] od_mask = 5'h01 << PA_OPEN_DRAIN_BIT;

  // Open-drain bit only ever pulls low
  assign pa_out_d  = lat_a_d & ~od_mask;
  assign pa_oe_n_d = dir_a_d | (lat_a_d & od_mask);
  // Pull-ups only on input pins
  assign pullup_d  = {PB_W{~cfg_d[PULLUP_DISABLE_N_BIT]}} & dir_b_d;
  assign alt_d     = {pa_s2_q[PA_OPEN_DRAIN_BIT], pb_s2_q[PB_EXT_IRQ_BIT],
                      pb_s2_q[PB_PROG_CLK_BIT], pb_s2_q[PB_PROG_DATA_BIT]};
  assign irq_d     = chg_flag_d & chg_en_d;
  assign wake_d    = i_sleep & irq_d;

  // Port A drivers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pa_out_q  <= '0;
      pa_oe_n_q <= '1;
    end else begin
      pa_out_q  <= pa_out_d;
      pa_oe_n_q <= pa_oe_n_d;
    end
  end

  // Port B drivers and weak pull-ups
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pb_out_q  <= '0;
      pb_oe_n_q <= '1;
      pullup_q  <= '0;
    end else begin
      pb_out_q  <= lat_b_d;
      pb_oe_n_q <= dir_b_d;
      pullup_q  <= pullup_d;
    end
  end

  // Alternate inputs, interrupt and wake
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      alt_q  <= 4'h0;
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      alt_q  <= alt_d;
      irq_q  <= irq_d;
      wake_q <= wake_d;
    end
  end

  // Outputs
  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready  = wready_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;
  assign o_pa_out        = pa_out_q;
  assign o_pa_oe_n       = pa_oe_n_q;
  assign o_pb_out        = pb_out_q;
  assign o_pb_oe_n       = pb_oe_n_q;
  assign o_pb_pullup_en  = pullup_q;
  assign o_timer_clk_in  = alt_q[3];
  assign o_ext_irq_in    = alt_q[2];
  assign o_prog_clk      = alt_q[1];
  assign o_prog_data     = alt_q[0];
  assign o_change_irq    = irq_q;
  assign o_wake          = wake_q;

endmodule

// *** hw/gpioc_pkg.sv ***
// Constants for the dual GPIO port block with change interrupt
package gpioc_pkg;

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_PORT_A_DATA      = 8'h05;
  localparam logic [7:0] IDX_PORT_B_DATA      = 8'h06;
  localparam logic [7:0] IDX_INTERRUPT_CTRL   = 8'h0b;
  localparam logic [7:0] IDX_TIMER_PULLUP_CFG = 8'h81;
  localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h86;

  // Bus geometry
  localparam int         AXI_ADDR_W  = 12;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Port widths
  localparam int PA_W = 5;
  localparam int PB_W = 8;

  // Field positions
  localparam int PULLUP_DISABLE_N_BIT = 7;
  localparam int CHG_IRQ_ENABLE_BIT   = 3;
  localparam int CHG_FLAG_BIT         = 0;
  localparam int PA_OPEN_DRAIN_BIT    = 4;
  localparam int PB_EXT_IRQ_BIT       = 0;
  localparam int PB_PROG_CLK_BIT      = 6;
  localparam int PB_PROG_DATA_BIT     = 7;
  localparam int PB_CHG_LO            = 4;

  // Reset values
  localparam logic [7:0]      TIMER_PULLUP_CFG_RST = 8'hff;
  localparam logic [PA_W-1:0] PORT_A_DIR_RST       = 5'h1f;
  localparam logic [PB_W-1:0] PORT_B_DIR_RST       = 8'hff;
  localparam logic [PA_W-1:0] PORT_A_LATCH_RST     = 5'h00;
  localparam logic [PB_W-1:0] PORT_B_LATCH_RST     = 8'h00;

  // Timing: a change must persist one instruction cycle
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         TCY_NS        = 160;
  localparam int         TCY_CYCLES    = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] CHG_CNT_MAX   = 3'(TCY_CYCLES - 1);

endpackage

// *** dv/gpioc_sva.sv ***
// Port-level checker for the GPIO block
module gpioc_sva
  import gpioc_pkg::*;
(
  // Clock and reset
  input wire logic                  i_ref_clk,
  input wire logic                  i_rst,
  // Bus
  input wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr,
  input wire logic                  i_s_axi_arvalid,
  input wire logic                  o_s_axi_arready,
  input wire logic [31:0]           o_s_axi_rdata,
  input wire logic [1:0]            o_s_axi_rresp,
  input wire logic                  o_s_axi_rvalid,
  input wire logic [1:0]            o_s_axi_bresp,
  input wire logic                  o_s_axi_bvalid,
  input wire logic                  i_s_axi_bready,
  // Pins and core
  input wire logic [PA_W-1:0]       i_pa_pin,
  input wire logic [PA_W-1:0]       o_pa_out,
  input wire logic [PB_W-1:0]       i_pb_pin,
  input wire logic [PB_W-1:0]       o_pb_out,
  input wire logic [PB_W-1:0]       o_pb_oe_n,
  input wire logic [PB_W-1:0]       o_pb_pullup_en,
  input wire logic                  o_timer_clk_in,
  input wire logic                  o_ext_irq_in,
  input wire logic                  o_prog_clk,
  input wire logic                  o_prog_data,
  input wire logic                  i_sleep,
  input wire logic                  o_change_irq,
  input wire logic                  o_wake
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [1:0] age_q;
  wire        ar_hs = i_s_axi_arvalid && o_s_axi_arready;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  property p_pull; (o_pb_pullup_en & ~o_pb_oe_n) == 8'h00; endproperty
  a_pull: assert property (p_pull) else $error("pull-up on driven pin");
  property p_od; o_pa_out[PA_OPEN_DRAIN_BIT] == 1'b0; endproperty
  a_od: assert property (p_od) else $error("open-drain bit drives high");
  property p_alt;
    age_q == 2'h3 |-> o_ext_irq_in == $past(i_pb_pin[0], 3) &&
      o_prog_clk == $past(i_pb_pin[6], 3) && o_prog_data == $past(i_pb_pin[7], 3) &&
      o_timer_clk_in == $past(i_pa_pin[4], 3);
  endproperty
  a_alt: assert property (p_alt) else $error("alternate input wrong");
  property p_wake; o_wake |-> $past(i_sleep) && o_change_irq; endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_pa_hi;
    ar_hs && i_s_axi_araddr[11:10] == 2'h0 && (i_s_axi_araddr[9:2] == IDX_PORT_A_DATA ||
      i_s_axi_araddr[9:2] == IDX_PORT_A_DIRECTION) |=> o_s_axi_rdata[7:5] == 3'h0;
  endproperty
  a_pa_hi: assert property (p_pa_hi) else $error("port A high bits set");
  property p_unm; ar_hs && i_s_axi_araddr[11:2] == 10'h010 |=>
    o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read accepted");
  property p_bhold; o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("response dropped");
  property p_latch; $changed(o_pb_out) || $changed(o_pb_oe_n) || $changed(o_pa_out)
    |-> $rose(o_s_axi_bvalid); endproperty
  a_latch: assert property (p_latch) else $error("latch moved without write");
  property p_rdz; o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read upper bits set");
  c_irq: cover property ($rose(o_change_irq));
  c_wake: cover property (o_wake);
  c_err: cover property (o_s_axi_rvalid && o_s_axi_rresp == RESP_SLVERR);
endmodule
bind gpioc_top gpioc_sva sva_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
  .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
  .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready), .i_pa_pin(i_pa_pin), .o_pa_out(o_pa_out),
  .i_pb_pin(i_pb_pin), .o_pb_out(o_pb_out), .o_pb_oe_n(o_pb_oe_n),
  .o_pb_pullup_en(o_pb_pullup_en), .o_timer_clk_in(o_timer_clk_in),
  .o_ext_irq_in(o_ext_irq_in), .o_prog_clk(o_prog_clk), .o_prog_data(o_prog_data),
  .i_sleep(i_sleep), .o_change_irq(o_change_irq), .o_wake(o_wake));

// *** dv/gpioc_pin_model.sv ***
// Pin-side model: keypad drive, pull-ups and floating lines
module gpioc_pin_model
  import gpioc_pkg::*;
(
  // Clock
  input  wire logic            i_ref_clk,
  // Port A
  input  wire logic [PA_W-1:0] i_pa_out,
  input  wire logic [PA_W-1:0] i_pa_oe_n,
  input  wire logic [PA_W-1:0] i_pa_ext,
  output logic [PA_W-1:0]      o_pa_pin,
  // Port B
  input  wire logic [PB_W-1:0] i_pb_out,
  input  wire logic [PB_W-1:0] i_pb_oe_n,
  input  wire logic [PB_W-1:0] i_pb_pullup_en,
  input  wire logic [PB_W-1:0] i_pb_ext,
  input  wire logic [PB_W-1:0] i_pb_ext_en,
  output logic [PB_W-1:0]      o_pb_pin
);
  logic [PB_W-1:0] last_q = '0;
  wire  [PB_W-1:0] pb_free = (i_pb_ext_en & i_pb_ext) |
                             (~i_pb_ext_en & (i_pb_pullup_en | ~last_q));
  always @(posedge i_ref_clk) last_q <= o_pb_pin;
  // Open-drain bit only ever drives low
  assign o_pa_pin = (~i_pa_oe_n & i_pa_out) | (i_pa_oe_n & i_pa_ext);
  assign o_pb_pin = (~i_pb_oe_n & i_pb_out) | (i_pb_oe_n & pb_free);
endmodule

// *** dv/tb_gpioc_top.sv ***
// Self-checking bench for the GPIO block
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_gpioc_top
  import gpioc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed { logic [7:0] i, d, e; logic [1:0] r; } gpioc_row_t;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_sleep = 1'b0;
  logic [AXI_ADDR_W-1:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [31:0] i_s_axi_wdata = '0, o_s_axi_rdata;
  logic [3:0] i_s_axi_wstrb = 4'h1;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp;
  logic [PA_W-1:0] i_pa_pin, o_pa_out, o_pa_oe_n, pa_ext = '0;
  logic [PB_W-1:0] i_pb_pin, o_pb_out, o_pb_oe_n, o_pb_pullup_en, pb_ext = '0, pb_en = '1;
  logic o_timer_clk_in, o_ext_irq_in, o_prog_clk, o_prog_data, o_change_irq, o_wake;
  logic [7:0] rd;
  int bad_count = 0, checks_done = 0, cyc = 0;
  gpioc_row_t rows [7] = '{
    '{IDX_PORT_A_DIRECTION, 8'hff, 8'h1f, RESP_OKAY}, '{IDX_PORT_A_DIRECTION, 8'h00, 8'h00, RESP_OKAY},
    '{IDX_PORT_B_DIRECTION, 8'h5a, 8'h5a, RESP_OKAY}, '{IDX_TIMER_PULLUP_CFG, 8'h7f, 8'h7f, RESP_OKAY},
    '{IDX_INTERRUPT_CTRL, 8'hff, 8'h09, RESP_OKAY}, '{IDX_INTERRUPT_CTRL, 8'h00, 8'h00, RESP_OKAY},
    '{8'h10, 8'hff, 8'h00, RESP_SLVERR}};
  gpioc_top dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
    .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
    .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
    .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp),
    .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
    .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready), .i_pa_pin(i_pa_pin), .o_pa_out(o_pa_out),
    .o_pa_oe_n(o_pa_oe_n), .i_pb_pin(i_pb_pin), .o_pb_out(o_pb_out),
    .o_pb_oe_n(o_pb_oe_n), .o_pb_pullup_en(o_pb_pullup_en),
    .o_timer_clk_in(o_timer_clk_in), .o_ext_irq_in(o_ext_irq_in),
    .o_prog_clk(o_prog_clk), .o_prog_data(o_prog_data), .i_sleep(i_sleep),
    .o_change_irq(o_change_irq), .o_wake(o_wake));
  gpioc_pin_model pins_u (.i_ref_clk(i_ref_clk), .i_pa_out(o_pa_out), .i_pa_oe_n(o_pa_oe_n),
    .i_pa_ext(pa_ext), .o_pa_pin(i_pa_pin), .i_pb_out(o_pb_out), .i_pb_oe_n(o_pb_oe_n),
    .i_pb_pullup_en(o_pb_pullup_en), .i_pb_ext(pb_ext), .i_pb_ext_en(pb_en),
    .o_pb_pin(i_pb_pin));
  always #20 i_ref_clk = ~i_ref_clk;
  task complete_run;
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input bit late = 1'b0);
    @(posedge i_ref_clk);
    i_s_axi_awaddr <= {2'h0, i, 2'h0};
    i_s_axi_wdata <= {24'h0, d};
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= !late;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_bvalid && !i_s_axi_bready) i_s_axi_bready <= 1'b1;
    end while (!(o_s_axi_bvalid && i_s_axi_bready));
    resp = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] i);
    @(posedge i_ref_clk);
    i_s_axi_araddr <= {2'h0, i, 2'h0};
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (!o_s_axi_rvalid);
    rd = o_s_axi_rdata[7:0];
    resp = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
  endtask
  initial begin
    hold(16);
    i_rst <= 1'b0;
    hold(1);
    `CHK(o_pb_pullup_en, 8'h00)
    `CHK(o_pb_oe_n, 8'hff)
    rdr(IDX_TIMER_PULLUP_CFG);
    `CHK(rd, 8'hff)
    rdr(IDX_PORT_A_DIRECTION);
    `CHK(rd, 8'h1f)
    rdr(IDX_PORT_B_DIRECTION);
    `CHK(rd, 8'hff)
    foreach (rows[k]) begin
      wr(rows[k].i, rows[k].d);
      `CHK(resp, rows[k].r)
      rdr(rows[k].i);
      `CHK(rd, rows[k].e)
      `CHK(resp, rows[k].r)
    end
    pa_ext <= 5'h1f;
    wr(IDX_PORT_A_DATA, 8'hff);
    `CHK(o_pa_out, 5'h0f)
    `CHK(o_pa_oe_n, 5'h10)
    hold(2);
    rdr(IDX_PORT_A_DATA);
    `CHK(rd, 8'h1f)
    `CHK(o_timer_clk_in, 1'b1)
    pa_ext <= 5'h00;
    wr(IDX_PORT_A_DATA, 8'h00);
    `CHK(o_pa_oe_n, 5'h00)
    `CHK(o_timer_clk_in, 1'b0)
    pb_ext <= 8'ha5;
    wr(IDX_PORT_B_DIRECTION, 8'h0f);
    hold(2);
    wr(IDX_PORT_B_DATA, 8'h3c);
    `CHK(o_pb_out, 8'h35)
    `CHK(o_pb_oe_n, 8'h0f)
    `CHK(o_pb_pullup_en, 8'h0f)
    `CHK(o_ext_irq_in, 1'b1)
    pb_en <= 8'h00;
    hold(4);
    rdr(IDX_PORT_B_DATA);
    `CHK(rd, 8'h3f)
    pb_en <= 8'hff;
    wr(IDX_TIMER_PULLUP_CFG, 8'hff);
    `CHK(o_pb_pullup_en, 8'h00)
    pb_ext <= 8'h00;
    wr(IDX_PORT_B_DIRECTION, 8'hf0);
    hold(4);
    rdr(IDX_PORT_B_DATA);
    wr(IDX_INTERRUPT_CTRL, 8'h08);
    pb_ext <= 8'h10;
    hold(2);
    pb_ext <= 8'h00;
    hold(8);
    rdr(IDX_INTERRUPT_CTRL);
    `CHK(rd, 8'h08)
    pb_ext <= 8'h10;
    hold(8);
    rdr(IDX_INTERRUPT_CTRL);
    `CHK(rd, 8'h09)
    `CHK(o_change_irq, 1'b1)
    i_sleep <= 1'b1;
    hold(3);
    `CHK(o_wake, 1'b1)
    i_sleep <= 1'b0;
    wr(IDX_INTERRUPT_CTRL, 8'h08);
    rdr(IDX_INTERRUPT_CTRL);
    `CHK(rd, 8'h09)
    rdr(IDX_PORT_B_DATA);
    `CHK(rd, 8'h15)
    wr(IDX_INTERRUPT_CTRL, 8'h08);
    rdr(IDX_INTERRUPT_CTRL);
    `CHK(rd, 8'h08)
    wr(IDX_PORT_B_DIRECTION, 8'he0);
    wr(IDX_PORT_B_DATA, 8'h00);
    pb_ext <= 8'h08;
    hold(8);
    rdr(IDX_INTERRUPT_CTRL);
    `CHK(rd, 8'h08)
    wr(IDX_TIMER_PULLUP_CFG, 8'h00, 1'b1);
    `CHK(resp, RESP_OKAY)
    `CHK(o_pb_pullup_en, 8'he0)
    hold(1);
    i_rst <= 1'b1;
    hold(2);
    i_rst <= 1'b0;
    hold(1);
    `CHK(o_pb_pullup_en, 8'h00)
    `CHK(o_pa_oe_n, 5'h1f)
    rdr(IDX_TIMER_PULLUP_CFG);
    `CHK(rd, 8'hff)
    complete_run();
  end
endmodule
